// *** fpe_pkg.sv ***
package fpe_pkg;
	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADR_CTRL_LOW = 8'h00;
	localparam logic [7:0] ADR_CTRL_HIGH = 8'h04;
	localparam logic [7:0] ADR_ESEL_LOW = 8'h08;
	localparam logic [7:0] ADR_ESEL_HIGH = 8'h0c;
	localparam logic [7:0] ADR_OVERLAY = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_PULSE = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_PVERIFY = 2;
	localparam int BIT_EVERIFY = 3;
	localparam int BIT_PSETUP = 4;
	localparam int BIT_ESETUP = 5;
	localparam int BIT_UNLOCK = 6;
	localparam int BIT_ERROR = 7;
	localparam int OVL_SEL_LO = 0;
	localparam int OVL_SEL_HI = 1;
	localparam int OVL_ENABLE = 2;
	localparam logic [7:0] CTRL_LOW_WMASK = 8'h7f;
	localparam logic [7:0] CTRL_HIGH_WMASK = 8'h3f;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_ESEL = 8'h00;
	localparam logic [2:0] RST_OVERLAY = 3'h0;
	// ----------------------------------------
	// Overlay geometry
	// ----------------------------------------
	localparam logic [3:0] OVL_AREA_TAG = 4'h8;
	localparam int OVL_BLK_AW = 12;
	typedef enum logic [2:0] {
		FM_READ = 3'b000,
		FM_PROGRAM = 3'b001,
		FM_ERASE = 3'b010,
		FM_PVERIFY = 3'b011,
		FM_EVERIFY = 3'b100
	} fpe_mode_e;
	typedef struct packed {
		logic flash_read;
		logic exception_entry;
		logic sleep_exec;
		logic bus_grant;
	} fpe_cpu_evt_s;
	typedef struct packed {
		logic wdt_reset;
		logic sw_standby;
		logic hw_standby;
		logic user_mode;
	} fpe_sys_s;
endpackage : fpe_pkg

// *** fpe_protect.sv ***
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fpe_protect
	import fpe_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic program_enable_pin,
	input wire fpe_sys_s sys,
	input wire fpe_cpu_evt_s evt,
	input wire logic [17:0] cpu_addr,
	input wire logic cpu_addr_valid,
	output logic apply_program_low,
	output logic apply_program_high,
	output logic apply_erase_low,
	output logic apply_erase_high,
	output logic apply_pverify_low,
	output logic apply_pverify_high,
	output logic apply_everify_low,
	output logic apply_everify_high,
	output logic [15:0] erase_blocks,
	output logic flash_error_flag,
	output logic ram_select,
	output logic [11:0] ram_addr
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] flash_ctrl_low_bank;
	logic [7:0] flash_ctrl_high_bank;
	logic [7:0] erase_select_low_bank;
	logic [7:0] erase_select_high_bank;
	logic [2:0] ram_overlay_register;
	fpe_mode_e mode;
	fpe_mode_e next_mode;
	logic exc_pending;
	logic next_error;
	logic clr_regs;
	logic err_clear;
	logic busy;
	logic reg_wr;
	logic bus_req;
	logic allow_pe;
	logic allow_verify;
	logic next_prog_low;
	logic next_prog_high;
	logic next_erase_low;
	logic next_erase_high;
	logic ovl_on;
	logic ovl_hit;
	logic [7:0] rd_byte;

	function automatic logic adr_is(input logic [7:0] a, input logic [7:0] r);
		adr_is = (a[7:2] == r[7:2]);
	endfunction : adr_is

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign reg_wr = bus_req & wb_we_i & wb_sel_i[0];
	// Pin low, watchdog reset and both standbys reinitialise the control and erase-select banks, not ram_overlay_register
	assign clr_regs = ~program_enable_pin | sys.wdt_reset | sys.sw_standby
		| sys.hw_standby;
	assign err_clear = sys.wdt_reset | sys.hw_standby;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flash_ctrl_low_bank <= RST_CTRL;
			flash_ctrl_high_bank <= RST_CTRL;
			erase_select_low_bank <= RST_ESEL;
			erase_select_high_bank <= RST_ESEL;
			ram_overlay_register <= RST_OVERLAY;
		end else if (clr_regs) begin
			flash_ctrl_low_bank <= RST_CTRL;
			flash_ctrl_high_bank <= RST_CTRL;
			erase_select_low_bank <= RST_ESEL;
			erase_select_high_bank <= RST_ESEL;
		end else if (reg_wr) begin
			// Error entry touches none of these, so contents survive it
			if (adr_is(wb_adr_i, ADR_CTRL_LOW)) begin
				flash_ctrl_low_bank <= wb_dat_i[7:0] & CTRL_LOW_WMASK;
			end
			if (adr_is(wb_adr_i, ADR_CTRL_HIGH)) begin
				flash_ctrl_high_bank <= wb_dat_i[7:0] & CTRL_HIGH_WMASK;
			end
			if (adr_is(wb_adr_i, ADR_ESEL_LOW)) begin
				erase_select_low_bank <= wb_dat_i[7:0];
			end
			if (adr_is(wb_adr_i, ADR_ESEL_HIGH)) begin
				erase_select_high_bank <= wb_dat_i[7:0];
			end
			if (adr_is(wb_adr_i, ADR_OVERLAY)) begin
				ram_overlay_register <= wb_dat_i[2:0];
			end
		end
	end

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		if (adr_is(wb_adr_i, ADR_CTRL_LOW)) begin
			rd_byte = flash_ctrl_low_bank;
		end else if (adr_is(wb_adr_i, ADR_CTRL_HIGH)) begin
			rd_byte = {flash_error_flag, flash_ctrl_high_bank[6:0]};
		end else if (adr_is(wb_adr_i, ADR_ESEL_LOW)) begin
			rd_byte = erase_select_low_bank;
		end else if (adr_is(wb_adr_i, ADR_ESEL_HIGH)) begin
			rd_byte = erase_select_high_bank;
		end else if (adr_is(wb_adr_i, ADR_OVERLAY)) begin
			rd_byte = {5'h00, ram_overlay_register};
		end else if (adr_is(wb_adr_i, ADR_STATUS)) begin
			rd_byte = {3'h0, ram_select, flash_error_flag, mode};
		end
	end

	// Unmapped addresses still ack, reading zero, so the master never hangs
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				wb_dat_o <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ----------------------------------------
	// Error protection
	// ----------------------------------------
	assign busy = apply_program_low | apply_program_high | apply_erase_low | apply_erase_high;
	assign next_error = ~err_clear & (flash_error_flag | exc_pending
		| (busy & (evt.flash_read | evt.sleep_exec | evt.bus_grant)));

	// Exception flags one cycle late, after the handler entry itself
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			exc_pending <= 1'b0;
		end else begin
			exc_pending <= busy & evt.exception_entry & ~err_clear;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flash_error_flag <= 1'b0;
		end else begin
			flash_error_flag <= next_error;
		end
	end

	// ----------------------------------------
	// Pulse gating
	// ----------------------------------------
	// Using next_error drops the pulse in the very cycle the flag rises
	assign allow_pe = program_enable_pin & flash_ctrl_low_bank[BIT_UNLOCK]
		& ~ram_overlay_register[OVL_ENABLE] & ~next_error & ~clr_regs;
	assign allow_verify = program_enable_pin & flash_ctrl_low_bank[BIT_UNLOCK] & ~clr_regs;
	assign next_prog_low = allow_pe & flash_ctrl_low_bank[BIT_PULSE];
	assign next_prog_high = allow_pe & flash_ctrl_high_bank[BIT_PULSE];
	assign next_erase_low = allow_pe & flash_ctrl_low_bank[BIT_ERASE]
		& (|erase_select_low_bank);
	assign next_erase_high = allow_pe & flash_ctrl_high_bank[BIT_ERASE]
		& (|erase_select_high_bank);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			apply_program_low <= 1'b0;
			apply_program_high <= 1'b0;
			apply_erase_low <= 1'b0;
			apply_erase_high <= 1'b0;
			apply_pverify_low <= 1'b0;
			apply_pverify_high <= 1'b0;
			apply_everify_low <= 1'b0;
			apply_everify_high <= 1'b0;
		end else begin
			apply_program_low <= next_prog_low;
			apply_program_high <= next_prog_high;
			apply_erase_low <= next_erase_low;
			apply_erase_high <= next_erase_high;
			apply_pverify_low <= allow_verify & flash_ctrl_low_bank[BIT_PVERIFY];
			apply_pverify_high <= allow_verify & flash_ctrl_high_bank[BIT_PVERIFY];
			apply_everify_low <= allow_verify & flash_ctrl_low_bank[BIT_EVERIFY];
			apply_everify_high <= allow_verify & flash_ctrl_high_bank[BIT_EVERIFY];
		end
	end

	// Only selected blocks of an erasing bank see the erase voltage
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			erase_blocks <= 16'h0000;
		end else begin
			erase_blocks <= {erase_select_high_bank & {8{next_erase_high}},
				erase_select_low_bank & {8{next_erase_low}}};
		end
	end

	// ----------------------------------------
	// Mode tracking
	// ----------------------------------------
	always_comb begin
		next_mode = FM_READ;
		if (next_erase_low | next_erase_high) begin
			next_mode = FM_ERASE;
		end else if (next_prog_low | next_prog_high) begin
			next_mode = FM_PROGRAM;
		end else if (allow_verify & (flash_ctrl_low_bank[BIT_PVERIFY]
			| flash_ctrl_high_bank[BIT_PVERIFY])) begin
			next_mode = FM_PVERIFY;
		end else if (allow_verify & (flash_ctrl_low_bank[BIT_EVERIFY]
			| flash_ctrl_high_bank[BIT_EVERIFY])) begin
			next_mode = FM_EVERIFY;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode <= FM_READ;
		end else begin
			case (next_mode)
				FM_READ, FM_PROGRAM, FM_ERASE, FM_PVERIFY, FM_EVERIFY: begin
					mode <= next_mode;
				end
				default: begin
					mode <= FM_READ;
				end
			endcase
		end
	end

	// ----------------------------------------
	// RAM overlay
	// ----------------------------------------
	// Erase gating above already excludes overlap, so RAM is never erased
	assign ovl_on = ram_overlay_register[OVL_ENABLE] & sys.user_mode;
	assign ovl_hit = cpu_addr_valid & ovl_on & (cpu_addr[17:14] == OVL_AREA_TAG)
		& (cpu_addr[13:12] == {ram_overlay_register[OVL_SEL_HI],
		ram_overlay_register[OVL_SEL_LO]});

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ram_select <= 1'b0;
			ram_addr <= 12'h000;
		end else begin
			ram_select <= ovl_hit;
			ram_addr <= cpu_addr[OVL_BLK_AW-1:0];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_pin_clears;
		!program_enable_pin |=> flash_ctrl_low_bank == 8'h00 && flash_ctrl_high_bank == 8'h00
			&& erase_select_low_bank == 8'h00 && erase_select_high_bank == 8'h00;
	endproperty
	a_pin_clears: assert property (p_pin_clears) else $error("pin low left registers set");

	property p_sys_init;
		(sys.wdt_reset || sys.sw_standby || sys.hw_standby) |=> flash_ctrl_low_bank == 8'h00
			&& erase_select_high_bank == 8'h00 && !busy;
	endproperty
	a_sys_init: assert property (p_sys_init) else $error("reset or standby did not init");

	property p_err_keeps;
		$rose(flash_error_flag) && !$past(reg_wr) && !$past(clr_regs)
			|-> flash_ctrl_low_bank == $past(flash_ctrl_low_bank)
			&& erase_select_low_bank == $past(erase_select_low_bank);
	endproperty
	a_err_keeps: assert property (p_err_keeps) else $error("error entry changed registers");

	property p_pin_blocks;
		!program_enable_pin |=> !busy;
	endproperty
	a_pin_blocks: assert property (p_pin_blocks) else $error("pulse with pin low");

	property p_unlock;
		!flash_ctrl_low_bank[BIT_UNLOCK] |=> !busy;
	endproperty
	a_unlock: assert property (p_unlock) else $error("pulse while locked");

	property p_esel;
		erase_select_high_bank == 8'h00 |=> !apply_erase_high;
	endproperty
	a_esel: assert property (p_esel) else $error("erase without block select");

	property p_overlap;
		ram_overlay_register[OVL_ENABLE] |=> !busy;
	endproperty
	a_overlap: assert property (p_overlap) else $error("pulse during overlap");

	property p_read_err;
		busy && evt.flash_read && !err_clear |=> flash_error_flag && !busy;
	endproperty
	a_read_err: assert property (p_read_err) else $error("flash read did not abort");

	property p_exc_err;
		busy && evt.exception_entry && !err_clear ##1 !err_clear |=> flash_error_flag;
	endproperty
	a_exc_err: assert property (p_exc_err) else $error("exception did not flag error");

	property p_bus_err;
		busy && (evt.sleep_exec || evt.bus_grant) && !err_clear |=> flash_error_flag;
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("sleep or grant did not flag");

	property p_err_sticky;
		flash_error_flag && !err_clear |=> flash_error_flag && !busy;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag lost or pulse ran");

	property p_err_verify;
		flash_error_flag && allow_verify && flash_ctrl_low_bank[BIT_PVERIFY] |=> apply_pverify_low;
	endproperty
	a_err_verify: assert property (p_err_verify) else $error("verify blocked in error");

	property p_ovl_map;
		cpu_addr_valid && sys.user_mode && ram_overlay_register == 3'b100
			&& cpu_addr[17:12] == 6'h20 |=> ram_select;
	endproperty
	a_ovl_map: assert property (p_ovl_map) else $error("block eight not overlaid");

	property p_ovl_off;
		!ram_overlay_register[OVL_ENABLE] |=> !ram_select;
	endproperty
	a_ovl_off: assert property (p_ovl_off) else $error("overlay stayed after disable");

	property p_ovl_noerase;
		ram_overlay_register[OVL_ENABLE] |=> erase_blocks == 16'h0000;
	endproperty
	a_ovl_noerase: assert property (p_ovl_noerase) else $error("erase ran during overlay");

	property p_err_mode;
		flash_error_flag |-> mode != FM_PROGRAM && mode != FM_ERASE;
	endproperty
	a_err_mode: assert property (p_err_mode) else $error("program or erase mode in error");

	c_program: cover property (!busy ##1 apply_program_low [*3]);
	c_erase_abort: cover property (apply_erase_high ##1 flash_error_flag);
	c_overlay: cover property (ram_select && ram_overlay_register == 3'b100);
	c_err_verify: cover property (flash_error_flag && apply_everify_low);
endmodule : fpe_protect
`default_nettype wire

// *** fpe_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fpe_cpu_model (
	input wire logic mclk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic ack,
	input wire logic [31:0] dat_in,
	output logic tmo
);
	// ----------------------------------------
	// Classic single-cycle bus master
	// ----------------------------------------
	initial begin
		{cyc, stb, we, adr, sel, dat, tmo} = '0;
	end

	// Request held until ack is sampled; ack read before that edge's updates
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		dat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		// Blocking, so the caller sees the timeout as soon as the task returns
		if (ack !== 1'b1) tmo = 1'b1;
		q = dat_in[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : xfer
endmodule : fpe_cpu_model
`default_nettype wire

// *** fpe_protect_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module fpe_protect_tb_top import fpe_pkg::*; ;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic pin = 1'b1;
	fpe_sys_s sys;
	fpe_cpu_evt_s evt;
	logic [17:0] cpu_addr;
	logic cpu_addr_valid;
	logic cyc, stb, we, ack, apl, aph, ael, aeh, pvl, pvh, evl, evh, flag, rsel;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [15:0] eblk;
	logic [11:0] raddr;
	int error_cnt = 0;
	int comparisons = 0;

	always #10 mclk = ~mclk;

	fpe_cpu_model cpu_u (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(wdat), .ack(ack), .dat_in(rdat), .tmo());

	fpe_protect dut_u (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .program_enable_pin(pin), .sys(sys), .evt(evt),
		.cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
		.apply_program_low(apl), .apply_program_high(aph), .apply_erase_low(ael),
		.apply_erase_high(aeh), .apply_pverify_low(pvl), .apply_pverify_high(pvh),
		.apply_everify_low(evl), .apply_everify_high(evh), .erase_blocks(eblk),
		.flash_error_flag(flag), .ram_select(rsel), .ram_addr(raddr));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic final_report;
		$display("checks %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		cpu_u.xfer(w, a, d, q);
		if (cpu_u.tmo) begin
			error_cnt++;
			final_report();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, q});
	endtask : rchk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic ovl(input logic [17:0] a, input logic e);
		@(posedge mclk);
		cpu_addr <= a;
		cpu_addr_valid <= 1'b1;
		@(posedge mclk);
		cpu_addr_valid <= 1'b0;
		#1;
		chk("ram_select", {15'h0000, e}, {15'h0000, rsel});
	endtask : ovl

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		sys = '0;
		sys.user_mode = 1'b1;
		evt = '0;
		cpu_addr = '0;
		cpu_addr_valid = 1'b0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 7; i++) rchk(8'(i * 4), 8'h00);
		$display("test reset_values finished");
		wr(ADR_CTRL_LOW, 8'h41);
		tick(2);
		chk("prog_low", 16'h1, {15'h0, apl});
		rchk(ADR_STATUS, 8'h01);
		wr(ADR_CTRL_LOW, 8'h01);
		tick(2);
		chk("prog_locked", 16'h0, {15'h0, apl});
		wr(ADR_CTRL_LOW, 8'h42);
		tick(2);
		chk("erase_unsel", 16'h0, {15'h0, ael});
		wr(ADR_ESEL_LOW, 8'h01);
		tick(2);
		chk("erase_low", 16'h1, {15'h0, ael});
		chk("erase_blocks", 16'h0001, eblk);
		rchk(ADR_STATUS, 8'h02);
		wr(ADR_OVERLAY, 8'h04);
		tick(2);
		chk("erase_ovl", 16'h0, {15'h0, ael});
		wr(ADR_OVERLAY, 8'h00);
		tick(2);
		chk("erase_back", 16'h1, {15'h0, ael});
		@(posedge mclk);
		pin <= 1'b0;
		tick(2);
		chk("erase_pin_low", 16'h0, {15'h0, ael});
		rchk(ADR_CTRL_LOW, 8'h00);
		rchk(ADR_ESEL_LOW, 8'h00);
		@(posedge mclk);
		pin <= 1'b1;
		wr(ADR_CTRL_LOW, 8'h40);
		wr(ADR_ESEL_HIGH, 8'h01);
		wr(ADR_CTRL_HIGH, 8'h02);
		tick(2);
		chk("erase_high", 16'h1, {15'h0, aeh});
		chk("erase_blocks_high", 16'h0100, eblk);
		@(posedge mclk);
		sys.sw_standby <= 1'b1;
		@(posedge mclk);
		sys.sw_standby <= 1'b0;
		tick(1);
		chk("erase_standby", 16'h0, {15'h0, aeh});
		rchk(ADR_ESEL_HIGH, 8'h00);
		$display("test protection finished");
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			sys.wdt_reset <= 1'b1;
			@(posedge mclk);
			sys.wdt_reset <= 1'b0;
			wr(ADR_CTRL_LOW, 8'h40);
			wr(ADR_CTRL_HIGH, 8'h01);
			tick(2);
			chk("prog_high", 16'h1, {15'h0, aph});
			@(posedge mclk);
			evt <= fpe_cpu_evt_s'(4'(1 << i));
			@(posedge mclk);
			evt <= '0;
			tick(3);
			chk("error_flag", 16'h1, {15'h0, flag});
			chk("prog_abort", 16'h0, {15'h0, aph});
		end
		rchk(ADR_CTRL_HIGH, 8'h81);
		rchk(ADR_CTRL_LOW, 8'h40);
		wr(ADR_CTRL_HIGH, 8'h00);
		wr(ADR_CTRL_HIGH, 8'h01);
		tick(2);
		chk("prog_in_error", 16'h0, {15'h0, aph});
		rchk(ADR_STATUS, 8'h08);
		wr(ADR_CTRL_HIGH, 8'h04);
		tick(2);
		chk("pverify_in_error", 16'h1, {15'h0, pvh});
		wr(ADR_CTRL_HIGH, 8'h08);
		tick(2);
		chk("everify_in_error", 16'h1, {15'h0, evh});
		wr(ADR_CTRL_LOW, 8'h44);
		tick(2);
		chk("pverify_low_error", 16'h1, {15'h0, pvl});
		wr(ADR_CTRL_LOW, 8'h48);
		tick(2);
		chk("everify_low_error", 16'h1, {15'h0, evl});
		@(posedge mclk);
		sys.hw_standby <= 1'b1;
		@(posedge mclk);
		sys.hw_standby <= 1'b0;
		tick(1);
		chk("flag_cleared", 16'h0, {15'h0, flag});
		rchk(ADR_CTRL_HIGH, 8'h00);
		$display("test error_protection finished");
		wr(ADR_OVERLAY, 8'h04);
		ovl(18'h20010, 1'b1);
		chk("ram_addr", 16'h0010, {4'h0, raddr});
		ovl(18'h21010, 1'b0);
		@(posedge mclk);
		sys.user_mode <= 1'b0;
		ovl(18'h20010, 1'b0);
		@(posedge mclk);
		sys.user_mode <= 1'b1;
		wr(ADR_OVERLAY, 8'h00);
		ovl(18'h20010, 1'b0);
		$display("test overlay finished");
		final_report();
	end
endmodule : fpe_protect_tb_top
`default_nettype wire
